// ### rtl/sst_sync_master_tx.sv
// Synchronous master transmit path of a serial port with plain register port.
// Assumes one 200 MHz clock, synchronous active-high reset and a pin pad outside.
`default_nettype none

module sst_sync_master_tx #(
	parameter int DATA_WIDTH = 8
) (
	// Clock and reset
	input  wire logic       CLOCK_IN,
	input  wire logic       RESET_IN,
	// Register port
	input  wire logic [2:0] ADDR_IN,
	input  wire logic [7:0] WDATA_IN,
	input  wire logic       WRITE_IN,
	input  wire logic       READ_IN,
	output var  logic [7:0] RDATA_OUT,
	// Clock pin
	input  wire logic       CLOCK_PIN_IN,
	output var  logic       CLOCK_PIN_OUT,
	output var  logic       CLOCK_PIN_OE_OUT,
	// Data pin
	input  wire logic       DATA_PIN_IN,
	output var  logic       DATA_PIN_OUT,
	output var  logic       DATA_PIN_OE_OUT,
	// Interrupt request level
	output var  logic       TX_IRQ_OUT
);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	sst_pkg::sst_tx_status_control_s tx_ctrl;
	logic [7:0]                      rx_ctrl;
	logic [7:0]                      baud_divisor;
	logic [7:0]                      irq_enable;
	logic [7:0]                      transmit_data;
	logic                            data_ninth;
	logic                            data_full;
	logic [8:0]                      transmit_shift_reg;
	logic [3:0]                      bits_left;
	logic [10:0]                     baud_count;
	sst_pkg::sst_state_e             state;
	sst_pkg::sst_bus_s               bus;
	logic [1:0]                      clock_pin_sync;
	logic [1:0]                      data_pin_sync;

	// Bus signals gathered into one carrier
	assign bus = '{write: WRITE_IN, read: READ_IN, addr: ADDR_IN, data: WDATA_IN};

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	logic port_on;
	logic master_tx;
	logic link_drive;
	logic load_shift;
	logic baud_tick;
	logic [10:0] baud_reload;
	logic tx_flag;

	// Synchronous master transmit only with port on, receivers off
	assign port_on = rx_ctrl[sst_pkg::RXSC_PORT_ENABLE];
	assign master_tx = port_on && tx_ctrl.clocked_mode
		&& tx_ctrl.clock_source_master
		&& !rx_ctrl[sst_pkg::RXSC_SINGLE_RECEIVE]
		&& !rx_ctrl[sst_pkg::RXSC_CONTINUOUS_RECEIVE]
		&& tx_ctrl.transmitter_enable;
	// Clock pin driver on whenever the port is a synchronous master
	// Clock driver stays on between characters so the line idles at a known level
	assign link_drive = port_on && tx_ctrl.clocked_mode && tx_ctrl.clock_source_master;

	// Half period in system clocks: divisor+1, times four unless high speed
	// Low speed with the largest divisor needs 1024 clocks, hence eleven bits
	function automatic logic [10:0] half_period(input logic [7:0] div, input logic hi);
		logic [10:0] base;
		base = {3'h0, div} + 11'h001;
		half_period = hi ? base : {base[8:0], 2'h0};
	endfunction

	assign baud_reload = half_period(baud_divisor, tx_ctrl.high_baud_select);
	assign baud_tick = (baud_count == 11'h001);
	// Holding register moves to an idle shifter at once
	assign load_shift = master_tx && data_full && (state == sst_pkg::SST_IDLE);

	// Transmit flag: transmitter enabled and holding register free, clear out of reset
	assign tx_flag = !data_full && tx_ctrl.transmitter_enable;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Control registers; the shifter itself has no address
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			tx_ctrl      <= sst_pkg::RESET_TX_STATUS_CONTROL;
			rx_ctrl      <= sst_pkg::RESET_ZERO;
			baud_divisor <= sst_pkg::RESET_ZERO;
			irq_enable   <= sst_pkg::RESET_ZERO;
		end else if (bus.write) begin
			unique case (bus.addr)
				sst_pkg::ADDR_TX_STATUS_CONTROL: begin
					tx_ctrl <= {bus.data[7:4], 1'b0, bus.data[2], tx_ctrl.shift_register_empty,
						bus.data[0]};
				end
				sst_pkg::ADDR_RX_STATUS_CONTROL: begin
					rx_ctrl <= bus.data;
				end
				sst_pkg::ADDR_BAUD_DIVISOR: begin
					baud_divisor <= bus.data;
				end
				sst_pkg::ADDR_PERIPH_IRQ_ENABLE: begin
					irq_enable <= bus.data;
				end
				default: begin
				end
			endcase
		end
	end

	// Holding register: write fills it, transfer to shifter empties it
	// A write in the transfer cycle wins, so the new character waits its turn
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			transmit_data <= sst_pkg::RESET_ZERO;
			data_ninth    <= 1'b0;
			data_full     <= 1'b0;
		end else if (bus.write && bus.addr == sst_pkg::ADDR_TRANSMIT_DATA) begin
			transmit_data <= bus.data;
			data_ninth    <= tx_ctrl.ninth_transmit_bit;
			data_full     <= 1'b1;
		end else if (load_shift || !port_on) begin
			data_full <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------
	// Counts half periods only while a character is shifting
	// Reloaded while idle so the first half period is always full length
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			baud_count <= 11'h001;
		end else if (state == sst_pkg::SST_IDLE || baud_tick) begin
			baud_count <= baud_reload;
		end else begin
			baud_count <= baud_count - 11'h001;
		end
	end

	// ------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------
	// Leading edge drives a bit, trailing edge lets the slave sample
	// Leaving master transmit drops a half-sent character and parks the clock low
	// The last low half runs out in full before the engine goes idle
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			state              <= sst_pkg::SST_IDLE;
			transmit_shift_reg <= 9'h000;
			bits_left          <= 4'h0;
			CLOCK_PIN_OUT      <= 1'b0;
			DATA_PIN_OUT       <= 1'b0;
		end else if (!master_tx) begin
			state         <= sst_pkg::SST_IDLE;
			CLOCK_PIN_OUT <= 1'b0;
		end else begin
			unique case (state)
				sst_pkg::SST_IDLE: begin
					CLOCK_PIN_OUT <= 1'b0;
					if (load_shift) begin
						// Data bits only, no framing bits
						transmit_shift_reg <= {data_ninth, transmit_data};
						bits_left <= tx_ctrl.nine_bit_transmit ? sst_pkg::BITS_NINE
							: sst_pkg::BITS_EIGHT;
						DATA_PIN_OUT  <= transmit_data[0];
						CLOCK_PIN_OUT <= 1'b1;
						state         <= sst_pkg::SST_LEAD;
					end
				end
				sst_pkg::SST_LEAD: begin
					if (baud_tick) begin
						CLOCK_PIN_OUT <= 1'b0;
						state         <= sst_pkg::SST_TRAIL;
						bits_left     <= bits_left - 4'h1;
						transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
					end
				end
				sst_pkg::SST_TRAIL: begin
					if (baud_tick) begin
						if (bits_left == 4'h0) begin
							state <= sst_pkg::SST_IDLE;
						end else begin
							DATA_PIN_OUT  <= transmit_shift_reg[0];
							CLOCK_PIN_OUT <= 1'b1;
							state         <= sst_pkg::SST_LEAD;
						end
					end
				end
				default: begin
					state <= sst_pkg::SST_IDLE; // Unused state code
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shifter-empty status and pin enables
	// ------------------------------------------------------------
	// Status bit tracks the engine; enables follow the mode
	// Interrupt level needs the flag, its enable and the port all on
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			CLOCK_PIN_OE_OUT <= 1'b0;
			DATA_PIN_OE_OUT  <= 1'b0;
			TX_IRQ_OUT       <= 1'b0;
		end else begin
			CLOCK_PIN_OE_OUT <= link_drive;
			DATA_PIN_OE_OUT  <= master_tx || (link_drive && state != sst_pkg::SST_IDLE);
			TX_IRQ_OUT       <= tx_flag && irq_enable[sst_pkg::IRQ_TRANSMIT_BIT]
				&& port_on;
		end
	end

	// Shifter empty whenever no character is shifting
	logic shifter_empty;
	assign shifter_empty = (state == sst_pkg::SST_IDLE) && !load_shift;

	// ------------------------------------------------------------
	// Pin sampling (kept synchronised, but no register read returns it)
	// ------------------------------------------------------------
	// Transmit never reads the pins back; only the second stage is meant to be read
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			clock_pin_sync <= 2'h0;
			data_pin_sync  <= 2'h0;
		end else begin
			clock_pin_sync <= {clock_pin_sync[0], CLOCK_PIN_IN};
			data_pin_sync  <= {data_pin_sync[0], DATA_PIN_IN};
		end
	end

	// ------------------------------------------------------------
	// Register reads, data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			RDATA_OUT <= 8'h00;
		end else if (bus.read) begin
			unique case (bus.addr)
				sst_pkg::ADDR_TX_STATUS_CONTROL: begin
					RDATA_OUT <= {tx_ctrl[7:4], 1'b0, tx_ctrl.high_baud_select, shifter_empty,
						tx_ctrl.ninth_transmit_bit};
				end
				sst_pkg::ADDR_RX_STATUS_CONTROL: begin
					RDATA_OUT <= rx_ctrl;
				end
				sst_pkg::ADDR_BAUD_DIVISOR: begin
					RDATA_OUT <= baud_divisor;
				end
				sst_pkg::ADDR_PERIPH_IRQ_ENABLE: begin
					RDATA_OUT <= irq_enable;
				end
				sst_pkg::ADDR_PERIPH_IRQ_FLAGS: begin
					RDATA_OUT <= {3'h0, tx_flag, 4'h0};
				end
				// Write-only data register and unused indices read zero
				default: begin
					RDATA_OUT <= 8'h00;
				end
			endcase
		end else begin
			RDATA_OUT <= 8'h00;
		end
	end

endmodule // sst_sync_master_tx

`default_nettype wire

// ### rtl/sst_pkg.sv
// Constants, register map and carrier types for the synchronous serial transmitter.
// Assumes a single 200 MHz system clock domain.
`default_nettype none

package sst_pkg;

	// ------------------------------------------------------------
	// Register indices (plain port addressing)
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_TX_STATUS_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_RX_STATUS_CONTROL = 3'h1;
	localparam logic [2:0] ADDR_BAUD_DIVISOR      = 3'h2;
	localparam logic [2:0] ADDR_TRANSMIT_DATA     = 3'h3;
	localparam logic [2:0] ADDR_PERIPH_IRQ_ENABLE = 3'h4;
	localparam logic [2:0] ADDR_PERIPH_IRQ_FLAGS  = 3'h5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_TX_STATUS_CONTROL = 8'h02;
	localparam logic [7:0] RESET_ZERO              = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	// Transmit status/control
	localparam int TXSC_CLOCK_SOURCE_MASTER = 7;
	localparam int TXSC_NINE_BIT_TRANSMIT   = 6;
	localparam int TXSC_TRANSMITTER_ENABLE  = 5;
	localparam int TXSC_CLOCKED_MODE        = 4;
	localparam int TXSC_HIGH_BAUD_SELECT    = 2;
	localparam int TXSC_SHIFT_REG_EMPTY     = 1;
	localparam int TXSC_NINTH_TRANSMIT_BIT  = 0;
	// Receive status/control
	localparam int RXSC_PORT_ENABLE         = 7;
	localparam int RXSC_SINGLE_RECEIVE      = 5;
	localparam int RXSC_CONTINUOUS_RECEIVE  = 4;
	// Peripheral interrupt enable and flags
	localparam int IRQ_TRANSMIT_BIT         = 4;

	// ------------------------------------------------------------
	// Character lengths and timing
	// ------------------------------------------------------------
	localparam logic [3:0] BITS_EIGHT       = 4'h8;
	localparam logic [3:0] BITS_NINE        = 4'h9;
	localparam int         LINK_SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SST_IDLE,
		SST_LEAD,
		SST_TRAIL
	} sst_state_e;

	typedef struct packed {
		logic clock_source_master;
		logic nine_bit_transmit;
		logic transmitter_enable;
		logic clocked_mode;
		logic unused_bit;
		logic high_baud_select;
		logic shift_register_empty;
		logic ninth_transmit_bit;
	} sst_tx_status_control_s;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [2:0] addr;
		logic [7:0] data;
	} sst_bus_s;

endpackage

`default_nettype wire

// ### sim/sst_master_tx_chk.sv
// Checker for the synchronous master transmitter, bound to its top module.
// Assumes one clock domain with synchronous active-high reset.
`default_nettype none

module sst_master_tx_chk (
	// Clock and reset
	input wire logic       CLOCK_IN,
	input wire logic       RESET_IN,
	// Register port
	input wire logic [2:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic       WRITE_IN,
	input wire logic       READ_IN,
	input wire logic [7:0] RDATA_OUT,
	// Pins and interrupt
	input wire logic       CLOCK_PIN_OUT,
	input wire logic       CLOCK_PIN_OE_OUT,
	input wire logic       DATA_PIN_OUT,
	input wire logic       DATA_PIN_OE_OUT,
	input wire logic       TX_IRQ_OUT
);
	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RESET_IN);
	// Both pin drivers released
	sequence s_oe_off;
		!CLOCK_PIN_OE_OUT && !DATA_PIN_OE_OUT;
	endsequence
	// No leading clock edge for eight cycles
	sequence s_quiet;
		!$rose(CLOCK_PIN_OUT) [*8];
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_high_data_hold: assert property (CLOCK_PIN_OUT && $past(CLOCK_PIN_OUT)
		|-> $stable(DATA_PIN_OUT))
		else $error("data moved inside the high half");
	a_trail_data_hold: assert property ($fell(CLOCK_PIN_OUT) |-> $stable(DATA_PIN_OUT))
		else $error("data moved on the trailing edge");
	a_clock_drv_on: assert property (CLOCK_PIN_OUT |-> CLOCK_PIN_OE_OUT)
		else $error("clock high with its driver off");
	a_data_drv_pair: assert property (DATA_PIN_OE_OUT |-> CLOCK_PIN_OE_OUT)
		else $error("data driven without the clock driver");
	a_shift_drives_data: assert property ($rose(CLOCK_PIN_OUT) |-> DATA_PIN_OE_OUT)
		else $error("bit shifted with data driver off");
	a_unmapped_zero: assert property (READ_IN && ADDR_IN > 3'h5 |=> RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	a_port_off: assert property (WRITE_IN && ADDR_IN == sst_pkg::ADDR_RX_STATUS_CONTROL
		&& !WDATA_IN[sst_pkg::RXSC_PORT_ENABLE] |-> ##3 s_oe_off)
		else $error("drivers on with port disabled");
	a_rx_mode: assert property (WRITE_IN && ADDR_IN == sst_pkg::ADDR_RX_STATUS_CONTROL
		&& (WDATA_IN[5] || WDATA_IN[4]) |-> ##3 !DATA_PIN_OE_OUT)
		else $error("data driven in receive mode");
	a_not_master: assert property (WRITE_IN && ADDR_IN == sst_pkg::ADDR_TX_STATUS_CONTROL
		&& !(WDATA_IN[7] && WDATA_IN[4]) |-> ##3 s_oe_off)
		else $error("drivers on outside synchronous master");
	a_transmitter_enable_off: assert property (WRITE_IN && ADDR_IN == sst_pkg::ADDR_TX_STATUS_CONTROL
		&& !WDATA_IN[5] |-> ##3 s_quiet)
		else $error("clock ran with transmitter disabled");
	a_irq_masked: assert property (WRITE_IN && ADDR_IN == sst_pkg::ADDR_PERIPH_IRQ_ENABLE
		&& !WDATA_IN[4] |-> ##3 !TX_IRQ_OUT)
		else $error("interrupt raised while masked");
endmodule // sst_master_tx_chk

bind sst_sync_master_tx sst_master_tx_chk u_chk (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WRITE_IN(WRITE_IN), .READ_IN(READ_IN),
	.RDATA_OUT(RDATA_OUT), .CLOCK_PIN_OUT(CLOCK_PIN_OUT), .CLOCK_PIN_OE_OUT(CLOCK_PIN_OE_OUT),
	.DATA_PIN_OUT(DATA_PIN_OUT), .DATA_PIN_OE_OUT(DATA_PIN_OE_OUT), .TX_IRQ_OUT(TX_IRQ_OUT));

`default_nettype wire

// ### sim/sst_slave_rx.sv
// Behavioural slave receiver on the far side of the synchronous link.
// Assumes the master makes the link clock; this model never drives the data line.
`default_nettype none

module sst_slave_rx (
	// Link lines
	input  wire logic        ck_in,
	input  wire logic        dt_in,
	// Bench control
	input  wire logic        clr_in,
	// Received bits
	output var  logic [15:0] word_out,
	output var  int          bits_out
);
	// Take one bit per trailing edge, no framing bits expected
	always @(negedge ck_in or posedge clr_in) begin
		if (clr_in) begin
			word_out <= 16'h0000;
			bits_out <= 0;
		end else begin
			word_out <= {dt_in, word_out[15:1]}; // First bit ends lowest
			bits_out <= bits_out + 1;
		end
	end
endmodule // sst_slave_rx

`default_nettype wire

// ### sim/test_sync_serial_master_tx.sv
// Self-checking bench for the synchronous master transmitter.
// Assumes the design package, the slave model and the bound checker are compiled first.
`default_nettype none

module test_sync_serial_master_tx;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  addr = 3'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        clr = 1'b1;
	logic        dt_last = 1'b0;
	logic [7:0]  rdata;
	logic        ck_o, ck_oe, dt_o, dt_oe, irq;
	logic [15:0] word;
	int          bits;
	int          fail_count = 0;
	int          checks = 0;
	int          cyc = 0;
	// Clock line idles low when released; data line shows the inverse of its last level
	wire         ck_w = ck_oe & ck_o;
	wire         dt_w = dt_oe ? dt_o : ~dt_last;

	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (dt_oe) dt_last <= dt_o;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			end_sim();
		end
	end

	sst_sync_master_tx uut (.CLOCK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WRITE_IN(wr_s), .READ_IN(rd_s), .RDATA_OUT(rdata), .CLOCK_PIN_IN(ck_w),
		.CLOCK_PIN_OUT(ck_o), .CLOCK_PIN_OE_OUT(ck_oe), .DATA_PIN_IN(dt_w),
		.DATA_PIN_OUT(dt_o), .DATA_PIN_OE_OUT(dt_oe), .TX_IRQ_OUT(irq));
	sst_slave_rx slave (.ck_in(ck_w), .dt_in(dt_w), .clr_in(clr), .word_out(word),
		.bits_out(bits));

	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		tick();
		wr_s <= 1'b0;
		tick();
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
		addr <= a;
		rd_s <= 1'b1;
		tick();
		rd_s <= 1'b0;
		chk(nm, 16'(rdata), 16'(exp));
		tick();
	endtask
	// Divisor first, then port, then mode
	task automatic cfg(input logic [7:0] tx, input logic [7:0] dv);
		wr(3'h2, dv);
		wr(3'h1, 8'h80);
		wr(3'h0, tx);
	endtask
	task automatic clear_rx;
		clr <= 1'b1;
		tick();
		clr <= 1'b0;
		tick();
	endtask
	task automatic wait_bits(input int n);
		for (int i = 0; i < 3000 && bits < n; i++) tick();
		repeat (60) tick();
		chk("bit count", 16'(bits), 16'(n));
	endtask
	task automatic t_char(input logic [7:0] tx, input logic [7:0] dv, input int hp);
		int n;
		n = 0;
		cfg(tx, dv);
		clear_rx();
		wr(3'h3, 8'hA5);
		while (ck_o !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		chk("start delay", 16'(n <= 4), 16'h0001);
		chk("pin drivers", {14'h0, ck_oe, dt_oe}, 16'h0003);
		rd(3'h0, tx, "busy status");
		while (ck_o === 1'b1) tick();
		while (ck_o !== 1'b1) tick();
		n = 0;
		while (ck_o === 1'b1 && n < 99) begin
			tick();
			n++;
		end
		chk("half period", 16'(n), 16'(hp));
		wait_bits(8);
		chk("char", 16'(word[15:8]), 16'h00A5);
		rd(3'h0, tx | 8'h02, "idle status");
	endtask
	// Character written while another shifts waits its turn
	task automatic t_b2b;
		cfg(8'hB4, 8'h01);
		clear_rx();
		wr(3'h3, 8'h3C);
		wr(3'h3, 8'hC3);
		wait_bits(16);
		chk("pair", word, 16'hC33C);
	endtask
	task automatic t_nine;
		cfg(8'hF5, 8'h01);
		clear_rx();
		wr(3'h3, 8'h5A);
		wait_bits(9);
		chk("nine bits", 16'(word[15:7]), 16'h015A);
	endtask
	// A setup lacking one condition must send nothing
	task automatic blocked(input logic [7:0] rx, input logic [7:0] tx);
		wr(3'h2, 8'h01);
		wr(3'h1, rx);
		wr(3'h0, tx);
		clear_rx();
		wr(3'h3, 8'h55);
		repeat (100) tick();
		chk("held off", 16'(bits), 16'h0000);
		cfg(8'hB4, 8'h01);
		repeat (100) tick();
	endtask
	task automatic t_irq;
		cfg(8'hB4, 8'h01);
		wr(3'h4, 8'h10);
		repeat (4) tick();
		chk("irq on", 16'(irq), 16'h0001);
		rd(3'h5, 8'h10, "flags");
		wr(3'h4, 8'h00);
		repeat (4) tick();
		chk("irq off", 16'(irq), 16'h0000);
	endtask
	task automatic end_sim;
		$display("Mismatches %0d in %0d checks", fail_count, checks);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		clr <= 1'b0;
		tick();
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), (i == 0) ? 8'h02 : 8'h00, "reset value");
		end
		t_char(8'hB4, 8'h01, 2);
		t_char(8'hB0, 8'h00, 4);
		t_b2b();
		t_nine();
		blocked(8'h00, 8'hB4);
		blocked(8'hA0, 8'hB4);
		blocked(8'h90, 8'hB4);
		blocked(8'h80, 8'h94);
		blocked(8'h80, 8'hA4);
		blocked(8'h80, 8'h34);
		t_irq();
		end_sim();
	end
endmodule // test_sync_serial_master_tx

`default_nettype wire
